// *** rtl/vec_encoder_consts.svh ***
/*
  Vector codes and source count for the vectored interrupt encoder.
  Assumes it is included by bare name from rtl files.
*/
`ifndef VEC_ENCODER_CONSTS_SVH
`define VEC_ENCODER_CONSTS_SVH

// Source count and reset value of the vector register
`define VEC_NUM_SRC        23
`define VEC_CODE_NONE      8'h00
// Endpoint codes
`define VEC_OUT_EP1        8'h12
`define VEC_OUT_EP2        8'h14
`define VEC_OUT_EP3        8'h16
`define VEC_IN_EP1         8'h22
`define VEC_IN_EP2         8'h24
`define VEC_IN_EP3         8'h26
// USB bus event codes
`define VEC_SETUP_OVR      8'h30
`define VEC_SETUP_RX       8'h32
`define VEC_RESUME         8'h38
`define VEC_SUSPEND        8'h3A
`define VEC_BUS_RESET      8'h3C
`define VEC_WAKEUP         8'h3E
// Serial unit and endpoint 0 codes
`define VEC_I2C_A          8'h40
`define VEC_I2C_B          8'h42
`define VEC_IN_EP0         8'h44
`define VEC_OUT_EP0        8'h46
`define VEC_UART_STATUS    8'h50
`define VEC_UART_MODEM     8'h52
`define VEC_UART_RX_FULL   8'h60
`define VEC_UART_TX_EMPTY  8'h62
// DMA codes
`define VEC_DMA1           8'h80
`define VEC_DMA3           8'h84

`endif

// *** rtl/vec_encoder_pkg.sv ***
/*
  Types for the vectored interrupt encoder.
  Assumes the consts header is on the include path.
*/
`include "vec_encoder_consts.svh"

package vec_encoder_pkg;

  typedef logic [7:0] vec_code_t;

  // Pending sources, one bit each, listed in the code order
  typedef struct packed {
    logic dma3;
    logic dma1;
    logic uart_tx_empty;
    logic uart_rx_full;
    logic uart_modem;
    logic uart_status;
    logic out_ep0;
    logic in_ep0;
    logic i2c_b;
    logic i2c_a;
    logic wakeup;
    logic bus_reset;
    logic suspend;
    logic resume;
    logic setup_rx;
    logic setup_ovr;
    logic in_ep3;
    logic in_ep2;
    logic in_ep1;
    logic out_ep3;
    logic out_ep2;
    logic out_ep1;
    logic reserved_pad;
  } src_vec_t;

  // Presented vector and its state
  typedef struct packed {
    vec_code_t code;
    logic      busy;
  } vec_state_t;

endpackage : vec_encoder_pkg

// *** rtl/vec_priority_pick.sv ***
/*
  Combinational pick of the largest code among pending sources.
  Assumes the pending word is stable within the cycle; no state.
*/
`timescale 1ns/1ps
`include "vec_encoder_consts.svh"

module vec_priority_pick (
  input  wire vec_encoder_pkg::src_vec_t pend_i,
  output logic [7:0]                     code_o
);

  // Code table, same order as the bits of src_vec_t
  function automatic logic [7:0] code_of(input int idx);
    unique case (idx)
      22:      code_of = `VEC_DMA3;
      21:      code_of = `VEC_DMA1;
      20:      code_of = `VEC_UART_TX_EMPTY;
      19:      code_of = `VEC_UART_RX_FULL;
      18:      code_of = `VEC_UART_MODEM;
      17:      code_of = `VEC_UART_STATUS;
      16:      code_of = `VEC_OUT_EP0;
      15:      code_of = `VEC_IN_EP0;
      14:      code_of = `VEC_I2C_B;
      13:      code_of = `VEC_I2C_A;
      12:      code_of = `VEC_WAKEUP;
      11:      code_of = `VEC_BUS_RESET;
      10:      code_of = `VEC_SUSPEND;
      9:       code_of = `VEC_RESUME;
      8:       code_of = `VEC_SETUP_RX;
      7:       code_of = `VEC_SETUP_OVR;
      6:       code_of = `VEC_IN_EP3;
      5:       code_of = `VEC_IN_EP2;
      4:       code_of = `VEC_IN_EP1;
      3:       code_of = `VEC_OUT_EP3;
      2:       code_of = `VEC_OUT_EP2;
      1:       code_of = `VEC_OUT_EP1;
      default: code_of = `VEC_CODE_NONE;
    endcase
  endfunction : code_of

  // Bits ascend with code, so the last set bit wins
  always_comb begin
    logic [22:0] bits;
    bits   = pend_i;
    code_o = `VEC_CODE_NONE;
    for (int i = 1; i < `VEC_NUM_SRC; i++) begin
      if (bits[i]) begin
        code_o = code_of(i);
      end
    end
  end

endmodule : vec_priority_pick

// *** rtl/vec_encoder.sv ***
/*
  Vectored interrupt encoder: latches source events, presents the largest
  pending code in the vector register, and retires it on firmware clears.
  Assumes source events are one-cycle pulses from logic on clk_sys_i, and
  that source flag clears come from those units on the same clock.
*/
`timescale 1ns/1ps
`include "vec_encoder_consts.svh"

module vec_encoder (
  input  wire logic                      clk_sys_i,
  input  wire logic                      reset_i,
  input  wire vec_encoder_pkg::src_vec_t event_i,
  input  wire vec_encoder_pkg::src_vec_t level_i,
  input  wire logic                      vec_clear_i,
  output logic [7:0]                     vector_code_register_o,
  output logic                           irq_pending_o,
  output vec_encoder_pkg::src_vec_t      pending_o
);

  typedef struct packed {
    vec_encoder_pkg::src_vec_t  latch;
    vec_encoder_pkg::vec_state_t vec;
  } state_t;

  state_t                     cur_ff;
  state_t                     nxt_cur;
  logic [7:0]                 pick_code;
  vec_encoder_pkg::src_vec_t  pend_all;
  logic [22:0]                latch_bits;
  logic [22:0]                code_bit;

  // Bit index of a presented code, used to retire its latched event
  function automatic logic [22:0] bit_of(input logic [7:0] code);
    logic [22:0] m;
    m = '0;
    unique case (code)
      `VEC_OUT_EP1:       m[1]  = 1'b1;
      `VEC_OUT_EP2:       m[2]  = 1'b1;
      `VEC_OUT_EP3:       m[3]  = 1'b1;
      `VEC_IN_EP1:        m[4]  = 1'b1;
      `VEC_IN_EP2:        m[5]  = 1'b1;
      `VEC_IN_EP3:        m[6]  = 1'b1;
      `VEC_I2C_A:         m[13] = 1'b1;
      `VEC_I2C_B:         m[14] = 1'b1;
      `VEC_IN_EP0:        m[15] = 1'b1;
      `VEC_OUT_EP0:       m[16] = 1'b1;
      default:            m     = '0;
    endcase
    bit_of = m;
  endfunction : bit_of

  // Level sources (USB, UART, DMA) stay pending until their own flag drops
  assign pend_all = vec_encoder_pkg::src_vec_t'(cur_ff.latch | level_i);

  vec_priority_pick u_pick (
    .pend_i (pend_all),
    .code_o (pick_code)
  );

  assign code_bit = bit_of(cur_ff.vec.code);

  // Next state: latch events, hold the vector until cleared, then repick
  always_comb begin
    nxt_cur = cur_ff;
    latch_bits = cur_ff.latch;
    if (vec_clear_i) begin
      // Endpoint/I2C events are owned by the vector only
      latch_bits = latch_bits & ~code_bit;
    end
    // New event wins over a same-cycle clear; token/I2C pulses land here
    latch_bits = latch_bits | event_i;
    latch_bits[0] = 1'b0;
    nxt_cur.latch = vec_encoder_pkg::src_vec_t'(latch_bits);
    if (vec_clear_i || !cur_ff.vec.busy) begin
      // Repick from what remains after the clear takes effect
      nxt_cur.vec.code = `VEC_CODE_NONE;
      nxt_cur.vec.busy = 1'b0;
    end
    if (!cur_ff.vec.busy && !vec_clear_i && pick_code != `VEC_CODE_NONE) begin
      nxt_cur.vec.code = pick_code;
      nxt_cur.vec.busy = 1'b1;
    end
  end

  // State register; the vector stays frozen while firmware services it
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign vector_code_register_o = cur_ff.vec.code;
  assign irq_pending_o          = cur_ff.vec.busy;
  assign pending_o              = cur_ff.latch;

  // Bit 0 of any presented code is zero and busy matches nonzero code
  a_code_form_ok: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (vector_code_register_o[0] == 1'b0) &&
    (irq_pending_o == (vector_code_register_o != 8'h00)))
    else $error("vector code malformed");

  // An idle encoder with a pending source presents it next cycle
  a_present_next: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!irq_pending_o && !vec_clear_i && pick_code != 8'h00)
      |=> (vector_code_register_o == $past(pick_code)))
    else $error("pending code not presented");

  // Vector holds steady until firmware clears it
  a_vector_holds: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (irq_pending_o && !vec_clear_i) |=> $stable(vector_code_register_o))
    else $error("vector changed without clear");

  // A clear drops the vector, and a remaining source shows one cycle later
  a_clear_repick: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (irq_pending_o && vec_clear_i) |=> (vector_code_register_o == 8'h00)
      ##1 ($past(vec_clear_i) || $past(pick_code) == 8'h00 ||
           irq_pending_o))
    else $error("repick after clear failed");

  // Endpoint event raised from idle shows within two cycles
  a_ep_event_seen: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (event_i == 23'h00_0002 && !irq_pending_o && !vec_clear_i &&
     pend_all == 23'h0)
      |=> ##1 (vector_code_register_o == 8'h12))
    else $error("endpoint code wrong");

  // Setup level alone from idle yields code 32
  a_setup_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pend_all == 23'h0000_0100 && !irq_pending_o && !vec_clear_i)
      |=> (vector_code_register_o == 8'h32))
    else $error("setup code wrong");

  // DMA3 alone from idle yields code 84
  a_dma3_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pend_all == 23'h40_0000 && !irq_pending_o && !vec_clear_i)
      |=> (vector_code_register_o == 8'h84))
    else $error("dma code wrong");

  // UART receive-full wins over UART status
  a_uart_prio: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pend_all.uart_rx_full && pend_all.uart_status && !pend_all.uart_tx_empty &&
     !pend_all.dma1 && !pend_all.dma3 && !irq_pending_o && !vec_clear_i)
      |=> (vector_code_register_o == 8'h60))
    else $error("uart priority wrong");

  // A token event pulse is latched into pending by the next cycle
  a_event_latch: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    event_i.in_ep0 |=> pending_o.in_ep0)
    else $error("event not latched");

  // Only table codes ever reach the vector register
  a_code_legal: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    vector_code_register_o inside {8'h00, 8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26,
      8'h30, 8'h32, 8'h38, 8'h3A, 8'h3C, 8'h3E, 8'h40, 8'h42, 8'h44, 8'h46,
      8'h50, 8'h52, 8'h60, 8'h62, 8'h80, 8'h84})
    else $error("reserved code presented");

  // Clearing code 12 retires its latched endpoint event
  a_ep_clear_drop: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (irq_pending_o && vec_clear_i && vector_code_register_o == 8'h12 && !event_i.out_ep1)
      |=> !pending_o.out_ep1)
    else $error("endpoint event not retired");

  // Input endpoint 0 alone from idle yields code 44
  a_in_ep0_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pend_all == 23'h00_8000 && !irq_pending_o && !vec_clear_i)
      |=> (vector_code_register_o == 8'h44))
    else $error("in ep0 code wrong");

  // Output endpoint 0 alone from idle yields code 46
  a_out_ep0_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pend_all == 23'h01_0000 && !irq_pending_o && !vec_clear_i)
      |=> (vector_code_register_o == 8'h46))
    else $error("out ep0 code wrong");

  // Setup overwrite alone from idle yields code 30
  a_ovr_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pend_all == 23'h00_0080 && !irq_pending_o && !vec_clear_i)
      |=> (vector_code_register_o == 8'h30))
    else $error("overwrite code wrong");

  // Wakeup alone from idle yields code 3E
  a_wakeup_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pend_all == 23'h00_1000 && !irq_pending_o && !vec_clear_i)
      |=> (vector_code_register_o == 8'h3E))
    else $error("wakeup code wrong");

  // Both I2C events with nothing higher: the larger code goes first
  a_i2c_prio: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pend_all[14:13] == 2'b11 && pend_all[22:15] == 8'h00 &&
     !irq_pending_o && !vec_clear_i)
      |=> (vector_code_register_o == 8'h42))
    else $error("i2c priority wrong");

  // DMA1 alone from idle yields code 80
  a_dma1_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pend_all == 23'h20_0000 && !irq_pending_o && !vec_clear_i)
      |=> (vector_code_register_o == 8'h80))
    else $error("dma1 code wrong");

  // Status flags are not latched without an event pulse, so the owning unit alone retires them
  a_level_unlatched: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!event_i.setup_rx && !pending_o.setup_rx)
      |=> !pending_o.setup_rx)
    else $error("level source latched");

  // With nothing pending the encoder stays idle
  a_idle_no_src: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!irq_pending_o && pick_code == 8'h00)
      |=> !irq_pending_o)
    else $error("spurious vector");

endmodule : vec_encoder

// *** verification/fw_service_model.sv ***
/*
  Firmware service model: takes each presented vector, clears its source
  flag, then clears the vector register. Assumes one shared clk_sys_i.
*/
`timescale 1ns/1ps

module fw_service_model (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] code_i,
  input  wire logic [3:0] delay_i,
  input  wire logic [7:0] req_type_i,
  input  wire logic       new_setup_i,
  output logic            flag_clear_o,
  output logic [7:0]      flag_code_o,
  output logic            vec_clear_o,
  output logic            usb_control_dir_o
);
  int wait_n;

  // Service loop; delay_i makes it answer promptly or slowly
  initial begin
    flag_clear_o      = 1'b0;
    flag_code_o       = 8'h00;
    vec_clear_o       = 1'b0;
    usb_control_dir_o = 1'b0;
    forever begin
      @(posedge clk_sys_i);
      #1;
      if (!reset_i && code_i != 8'h00) begin
        flag_code_o = code_i;
        wait_n      = delay_i;
        if (code_i == 8'h32) begin
          usb_control_dir_o = req_type_i[7];
          // Newer setup pending: abandon the serve time
          if (new_setup_i) wait_n = 0;
        end
        repeat (wait_n) @(posedge clk_sys_i);
        // Newer setup after serving: decode anew
        if (code_i == 8'h32 && new_setup_i) usb_control_dir_o = req_type_i[7];
        #1;
        flag_clear_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        flag_clear_o = 1'b0;
        flag_code_o  = ~flag_code_o; // Stale once released
        vec_clear_o  = 1'b1;
        @(posedge clk_sys_i);
        #1;
        vec_clear_o = 1'b0;
      end
    end
  end
endmodule : fw_service_model

// *** verification/vec_encoder_bench.sv ***
/*
  Self-checking bench for the vectored interrupt encoder.
  Assumes the rtl package, header and design files are compiled first.
*/
`timescale 1ns/1ps

module vec_encoder_bench;
  logic                      clk_sys_i = 1'b0;
  logic                      reset_i   = 1'b1;
  vec_encoder_pkg::src_vec_t event_i   = '0;
  vec_encoder_pkg::src_vec_t level_i   = '0;
  vec_encoder_pkg::src_vec_t level_req = '0;
  logic [7:0]                req_type  = 8'h00;
  logic                      usb_dir;
  vec_encoder_pkg::src_vec_t pending;
  logic [3:0]                delay_i   = 4'h0;
  logic                      vec_clear, flag_clear, irq;
  logic [7:0]                code, flag_code;
  logic [7:0]                exp_q[$];
  int                        miscompares = 0;
  int                        n_compared  = 0;
  // Code of each source bit, bit 0 is padding
  logic [7:0] code_of [23] = '{8'h00, 8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26, 8'h30,
    8'h32, 8'h38, 8'h3A, 8'h3C, 8'h3E, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50, 8'h52, 8'h60,
    8'h62, 8'h80, 8'h84};

  initial forever #2.5 clk_sys_i = ~clk_sys_i;

  vec_encoder vec_encoder_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .event_i(event_i), .level_i(level_i), .vec_clear_i(vec_clear),
    .vector_code_register_o(code), .irq_pending_o(irq), .pending_o(pending));

  fw_service_model fw_service_model_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .code_i(code), .delay_i(delay_i), .req_type_i(req_type),
    .new_setup_i(level_i.setup_ovr), .flag_clear_o(flag_clear),
    .flag_code_o(flag_code), .vec_clear_o(vec_clear), .usb_control_dir_o(usb_dir));

  // Owning units raise flags on request and drop one when firmware clears it
  always @(posedge clk_sys_i) begin
    vec_encoder_pkg::src_vec_t drop;
    drop = '0;
    if (flag_clear)
      for (int i = 1; i < 23; i++)
        if (code_of[i] == flag_code) drop[i] = 1'b1;
    level_i <= (level_i | level_req) & ~drop;
  end

  // Oldest note against each vector the firmware services
  always @(posedge clk_sys_i)
    if (flag_clear) begin
      n_compared++;
      if (exp_q.size() == 0 || flag_code !== exp_q[0] || irq !== 1'b1) begin
        miscompares++;
        $display("ERROR t=%0t got=%h exp=%h", $time, flag_code,
                 exp_q.size() ? exp_q[0] : 8'hFF);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
      if (flag_code == 8'h32 && usb_dir !== req_type[7]) begin
        miscompares++;
        $display("ERROR t=%0t got=%h exp=%h", $time, usb_dir, req_type[7]);
      end
    end

  // Latched events against what should be held
  task automatic check_pending(input logic [22:0] exp);
    n_compared++;
    if (pending !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, pending, exp);
    end
  endtask : check_pending

  task automatic print_verdict();
    $display("Compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Wait until every note is served and the vector reads zero
  task automatic settle();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || code !== 8'h00) && n < 2000) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    if (n == 2000) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, code, 8'h00);
      disable main_seq;
    end
    repeat (3) @(posedge clk_sys_i);
    #1;
    check_pending(23'h00_0000);
  endtask : settle

  // Pulse sources in one cycle, then level sources; expect descending codes
  task automatic run(input logic [22:0] mask);
    logic [22:0] pm, lm;
    pm = mask & 23'h1_E07E;
    lm = mask & 23'h7E_1F80;
    delay_i = 4'($urandom_range(15));
    req_type = 8'($urandom);
    for (int i = 22; i > 0; i--) if (pm[i]) exp_q.push_back(code_of[i]);
    event_i = vec_encoder_pkg::src_vec_t'(pm);
    @(posedge clk_sys_i);
    #1 event_i = '0;
    check_pending(pm);
    settle();
    for (int i = 22; i > 0; i--) if (lm[i]) exp_q.push_back(code_of[i]);
    level_req = vec_encoder_pkg::src_vec_t'(lm);
    @(posedge clk_sys_i);
    #1 level_req = '0;
    settle();
  endtask : run

  // Main sequence
  initial begin
    void'($urandom(67));
    repeat (12) @(posedge clk_sys_i);
    #1 reset_i = 1'b0;
    begin : main_seq
      for (int i = 1; i < 23; i++) run(23'h1 << i);
      run(23'h7F_FFFE);
      repeat (20) run(23'($urandom));
      // A higher arrival waits while a code is presented
      exp_q.push_back(8'h12);
      exp_q.push_back(8'h84);
      event_i.out_ep1 = 1'b1;
      delay_i = 4'hF;
      @(posedge clk_sys_i);
      #1 event_i = '0;
      repeat (2) @(posedge clk_sys_i);
      #1 level_req.dma3 = 1'b1;
      @(posedge clk_sys_i);
      #1 level_req = '0;
      settle();
    end
    print_verdict();
  end
endmodule : vec_encoder_bench
